// ===== src/tboc_pkg.sv
package tboc_pkg;
   localparam int          CLK_HZ        = 40_000_000;
   localparam int          TONE_HZ       = 1300;
   localparam int          CLEAR_LEAD_NS = 2500;
   localparam int          BURST_MS      = 90;
   localparam int          WORD_STEPS    = 17;
   localparam int          BURST_STEPS   = 15;
   localparam int          WORD_W        = 17;
   localparam int          LINES         = 2;
   localparam int          FRAMES        = 2;
   localparam int          SYNC_STEP     = 15;
   localparam int          CHECK_STEP    = 17;
   localparam int          SEARCH_STEP   = 1;
   localparam int          CNT_W         = 8;
   localparam int          PHASE_W       = 20;
   localparam int          BSTEP_W       = 20;
   localparam int          STEP_W        = 5;
   // longest time rounds down, least time rounds up
   localparam int          PHASE_CYC     = CLK_HZ / TONE_HZ;
   localparam int          CLEAR_CYC     =
      (CLEAR_LEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int          BSTEP_CYC     =
      (CLK_HZ / 1000) * BURST_MS / BURST_STEPS;
   localparam logic [CNT_W-1:0] BURST_CNT_RST = 8'h00;
   localparam logic [LINES-1:0] PARITY_RST    = 2'h0;

   typedef enum logic [2:0]
   {
      TBOC_IDLE = 3'b001,
      TBOC_SYNC = 3'b010,
      TBOC_DATA = 3'b100
   } tboc_seq_t;
endpackage

// ===== src/tboc_top.sv
`timescale 1ns/1ps

// three-stage synchroniser; a change counts once stages two and three agree
module tboc_sync3
#(
   parameter int W = 1
)
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] agree;

   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q    <= '0;
      end
      else
      begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q    <= (agree & s3_r) | (~agree & q);
      end
   end
endmodule

module tboc_top
#(
   parameter int PHASE_CYC = tboc_pkg::PHASE_CYC,
   parameter int BSTEP_CYC = tboc_pkg::BSTEP_CYC
)
(
   input  wire logic                        clk,
   input  wire logic                        rstn,
   input  wire logic                        link_clk,
   input  wire logic [tboc_pkg::CNT_W-1:0]  offer_burst_num,
   input  wire logic                        offer_valid,
   input  wire logic                        offer_other_ok,
   output logic                             offer_accept,
   output logic                             burst_compare,
   output logic                             burst_no_compare,
   output logic [tboc_pkg::CNT_W-1:0]       burst_count,
   input  wire logic                        burst_cnt_clear,
   input  wire logic                        msg_complete,
   input  wire logic [tboc_pkg::WORD_W-1:0] word_line1,
   input  wire logic [tboc_pkg::WORD_W-1:0] word_line2,
   output logic                             word_taken,
   output logic                             out_alarm,
   input  wire logic                        alarm_clear,
   input  wire logic                        tone_in,
   output logic [tboc_pkg::LINES-1:0]       line_data_out,
   output logic [tboc_pkg::LINES-1:0]       line_sync_out,
   output logic [tboc_pkg::LINES-1:0]       line_timing_out
);
   localparam int W  = tboc_pkg::WORD_W;
   localparam int NL = tboc_pkg::LINES;
   localparam int PW = tboc_pkg::PHASE_W;
   localparam int BW = tboc_pkg::BSTEP_W;
   localparam int SW = tboc_pkg::STEP_W;
   localparam logic [PW-1:0] PH_LAST  = PW'(PHASE_CYC - 1);
   localparam logic [PW-1:0] PH_CLEAR =
      PW'(PHASE_CYC - 1 - tboc_pkg::CLEAR_CYC);
   localparam logic [BW-1:0] BS_LAST  = BW'(BSTEP_CYC - 1);
   localparam logic [SW-1:0] WS_LAST  = SW'(tboc_pkg::WORD_STEPS);
   localparam logic [SW-1:0] BS_STEPS = SW'(tboc_pkg::BURST_STEPS);
   localparam logic [SW-1:0] ST_ONE   = 5'h01;
   localparam logic [SW-1:0] ST_SRCH  = SW'(tboc_pkg::SEARCH_STEP);
   localparam logic [SW-1:0] ST_SYNC  = SW'(tboc_pkg::SYNC_STEP);
   localparam logic [SW-1:0] ST_CHECK = SW'(tboc_pkg::CHECK_STEP);

   // timing chain, system clock side
   logic [PW-1:0]        ph_cnt_r;
   logic [SW-1:0]        wstep_r;
   logic [BW-1:0]        bs_cyc_r;
   logic [SW-1:0]        bstep_r;
   logic [tboc_pkg::CNT_W-1:0] burst_cnt_r;
   logic                 data_phase;
   logic                 clear_phase;
   logic                 bstep_adv;
   logic                 search_pulse;
   logic [SW-1:0]        bstep_nxt;

   assign data_phase   = (ph_cnt_r == PH_LAST);
   assign clear_phase  = (ph_cnt_r == PH_CLEAR);
   assign bstep_adv    = (bs_cyc_r == BS_LAST);
   assign bstep_nxt    = (bstep_r == BS_STEPS) ? ST_ONE : bstep_r + ST_ONE;
   assign search_pulse = bstep_adv && (bstep_nxt == ST_SRCH);

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ph_cnt_r <= '0;
         wstep_r  <= ST_ONE;
         bs_cyc_r <= '0;
         bstep_r  <= BS_STEPS;
      end
      else
      begin
         ph_cnt_r <= data_phase ? '0 : ph_cnt_r + 1'b1;
         if (data_phase)
            wstep_r <= (wstep_r == WS_LAST) ? ST_ONE : wstep_r + ST_ONE;
         bs_cyc_r <= bstep_adv ? '0 : bs_cyc_r + 1'b1;
         if (bstep_adv)
            bstep_r <= bstep_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         burst_cnt_r <= tboc_pkg::BURST_CNT_RST;
      else if (burst_cnt_clear)
         burst_cnt_r <= tboc_pkg::BURST_CNT_RST;
      else if (search_pulse)
         burst_cnt_r <= burst_cnt_r + 8'h01;
   end

   assign burst_count = burst_cnt_r;

   // mismatch gates: each pairs a bit with the opposite state of its twin
   logic [2*tboc_pkg::CNT_W-1:0] mism_gate;
   assign mism_gate = {offer_burst_num & ~burst_cnt_r,
                       ~offer_burst_num & burst_cnt_r};
   assign burst_no_compare = |mism_gate;
   assign burst_compare    = ~burst_no_compare;
   // the computer stamps a whole burst alike, so per-word match suffices
   assign offer_accept = offer_valid && offer_other_ok
                         && burst_compare;

   // readout sequencer
   tboc_pkg::tboc_seq_t seq_r;
   tboc_pkg::tboc_seq_t seq_nxt;
   logic                start_req_r;
   logic                frame_r;
   logic                fill_r;
   logic [W-1:0]        sh1_r;
   logic [W-1:0]        sh2_r;
   logic [NL-1:0]       bits_r;
   logic                sync_bit_r;
   logic                ph_tg_r;
   logic                clr_tg_r;
   logic                taken_r;
   logic                at_last;
   logic                at_sync;
   logic                do_load;
   logic                in_data;
   logic [NL-1:0]       cur_bits;

   assign at_last  = data_phase && (wstep_r == WS_LAST);
   assign at_sync  = data_phase && (wstep_r == ST_SYNC)
                     && (seq_r == tboc_pkg::TBOC_SYNC);
   assign in_data  = (seq_r == tboc_pkg::TBOC_DATA);
   assign do_load  = at_last && ((seq_r == tboc_pkg::TBOC_SYNC)
                     || (in_data && !frame_r));
   // filler: a single one on both lines at the last step of the word
   assign cur_bits = fill_r ? {NL{wstep_r == WS_LAST}}
                            : {sh2_r[W-1], sh1_r[W-1]};

   always_comb
   begin
      seq_nxt = seq_r;
      case (seq_r)
         tboc_pkg::TBOC_IDLE:
            if (start_req_r && data_phase && wstep_r == ST_ONE)
               seq_nxt = tboc_pkg::TBOC_SYNC;
         tboc_pkg::TBOC_SYNC:
            if (at_last)
               seq_nxt = tboc_pkg::TBOC_DATA;
         tboc_pkg::TBOC_DATA:
            if (at_last && frame_r)
               seq_nxt = tboc_pkg::TBOC_IDLE;
         default:
            seq_nxt = tboc_pkg::TBOC_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         seq_r       <= tboc_pkg::TBOC_IDLE;
         start_req_r <= 1'b0;
         frame_r     <= 1'b0;
         fill_r      <= 1'b1;
         sh1_r       <= '0;
         sh2_r       <= '0;
         taken_r     <= 1'b0;
      end
      else
      begin
         seq_r <= seq_nxt;
         if (search_pulse)
            start_req_r <= 1'b1;
         else if (seq_nxt == tboc_pkg::TBOC_SYNC)
            start_req_r <= 1'b0;
         taken_r <= do_load && msg_complete;
         if (do_load)
         begin
            frame_r <= in_data;
            fill_r  <= !msg_complete;
            sh1_r   <= word_line1;
            sh2_r   <= word_line2;
         end
         else if (data_phase && in_data)
         begin
            sh1_r <= {sh1_r[W-2:0], 1'b0};
            sh2_r <= {sh2_r[W-2:0], 1'b0};
         end
      end
   end

   assign word_taken = taken_r;

   // phase bits are held a whole bit time, so the link side reads them
   // after the toggle crossing without a multi-bit hazard
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         bits_r     <= '0;
         sync_bit_r <= 1'b0;
         ph_tg_r    <= 1'b0;
         clr_tg_r   <= 1'b0;
      end
      else
      begin
         if (data_phase)
         begin
            bits_r     <= in_data ? cur_bits : '0;
            sync_bit_r <= at_sync;
            ph_tg_r    <= ~ph_tg_r;
         end
         if (clear_phase)
            clr_tg_r <= ~clr_tg_r;
      end
   end

   // parity check
   logic [NL-1:0] par_r;
   logic          chk_arm_r;
   logic          alarm_r;
   logic          chk_strobe;
   logic          bad_word;

   assign chk_strobe = chk_arm_r;
   assign bad_word   = ~&par_r;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         par_r     <= tboc_pkg::PARITY_RST;
         chk_arm_r <= 1'b0;
         alarm_r   <= 1'b0;
      end
      else
      begin
         chk_arm_r <= data_phase && in_data
                      && (wstep_r == ST_CHECK);
         if (chk_strobe)
            par_r <= tboc_pkg::PARITY_RST;
         else if (data_phase && in_data)
            par_r <= par_r ^ cur_bits;
         // a fresh alarm wins over a clear in the same cycle
         if (chk_strobe && bad_word)
            alarm_r <= 1'b1;
         else if (alarm_clear)
            alarm_r <= 1'b0;
      end
   end

   assign out_alarm = alarm_r;

   // link side: conversion channels on the link clock
   logic [2:0]  lk_in;
   logic [2:0]  lk_q;
   logic        ph_seen_r;
   logic        clr_seen_r;
   logic        ph_ev;
   logic        clr_ev;
   logic        tone_f;

   assign lk_in = {tone_in, clr_tg_r, ph_tg_r};

   tboc_sync3 #(.W(3)) u_lk_sync
   (
      .clk  (link_clk),
      .rstn (rstn),
      .d    (lk_in),
      .q    (lk_q)
   );

   assign ph_ev  = lk_q[0] ^ ph_seen_r;
   assign clr_ev = lk_q[1] ^ clr_seen_r;
   assign tone_f = lk_q[2];

   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ph_seen_r  <= 1'b0;
         clr_seen_r <= 1'b0;
      end
      else
      begin
         ph_seen_r  <= lk_q[0];
         clr_seen_r <= lk_q[1];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NL; gi++)
      begin : g_chan
         logic dff_r;
         logic sff_r;
         logic dout_r;
         logic sout_r;
         logic tout_r;

         always_ff @(posedge link_clk or negedge rstn)
         begin
            if (!rstn)
            begin
               dff_r  <= 1'b0;
               sff_r  <= 1'b0;
               dout_r <= 1'b0;
               sout_r <= 1'b0;
               tout_r <= 1'b0;
            end
            else
            begin
               if (ph_ev && bits_r[gi])
                  dff_r <= 1'b1;
               else if (clr_ev)
                  dff_r <= 1'b0;
               if (ph_ev && sync_bit_r)
                  sff_r <= 1'b1;
               else if (clr_ev)
                  sff_r <= 1'b0;
               dout_r <= dff_r & tone_f;
               sout_r <= sff_r & tone_f;
               tout_r <= tone_f;
            end
         end

         assign line_data_out[gi]   = dout_r;
         assign line_sync_out[gi]   = sout_r;
         assign line_timing_out[gi] = tout_r;
      end
   endgenerate
endmodule

// ===== test/tboc_assertions.sv
`timescale 1ns/1ps
module tboc_checker
#(
   parameter int PHASE_CYC = 200,
   parameter int BSTEP_CYC = 13600
)
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        link_clk,
   input wire logic [7:0]  offer_burst_num,
   input wire logic        offer_valid,
   input wire logic        offer_other_ok,
   input wire logic        offer_accept,
   input wire logic        burst_compare,
   input wire logic        burst_no_compare,
   input wire logic [7:0]  burst_count,
   input wire logic        burst_cnt_clear,
   input wire logic        word_taken,
   input wire logic        out_alarm,
   input wire logic        alarm_clear,
   input wire logic        tone_in,
   input wire logic [1:0]  line_data_out,
   input wire logic [1:0]  line_sync_out,
   input wire logic [1:0]  line_timing_out
);
   a_accept_needs_match: assert property (
      @(posedge clk) disable iff (!rstn)
      offer_accept == (offer_valid && offer_other_ok && burst_compare))
      else $error("accept without all conditions");
   a_compare_equal: assert property (
      @(posedge clk) disable iff (!rstn)
      burst_compare == (offer_burst_num == burst_count))
      else $error("compare differs from equality");
   a_no_compare_inv: assert property (
      @(posedge clk) disable iff (!rstn)
      burst_no_compare != burst_compare)
      else $error("no-compare not inverse");
   a_count_step_one: assert property (
      @(posedge clk) disable iff (!rstn)
      $changed(burst_count) && !$past(burst_cnt_clear)
      |-> burst_count == $past(burst_count) + 8'h01)
      else $error("burst count moved by other than one");
   a_count_clear: assert property (
      @(posedge clk) disable iff (!rstn)
      burst_cnt_clear |=> burst_count == 8'h00)
      else $error("burst count not cleared");
   a_alarm_sticky: assert property (
      @(posedge clk) disable iff (!rstn)
      out_alarm && !alarm_clear |=> out_alarm)
      else $error("alarm dropped without clear");
   a_taken_one_cycle: assert property (
      @(posedge clk) disable iff (!rstn)
      word_taken |=> !word_taken [*2])
      else $error("word taken pulse too long");
   a_timing_lines_same: assert property (
      @(posedge link_clk) disable iff (!rstn)
      line_timing_out[0] == line_timing_out[1])
      else $error("timing lines differ");
   // three sync stages, the agree stage and the output flop: five edges
   a_timing_follows_tone: assert property (
      @(posedge link_clk) disable iff (!rstn)
      $past(rstn, 5) |-> line_timing_out[0] == $past(tone_in, 5))
      else $error("timing line does not follow tone");
   a_sync_data_apart: assert property (
      @(posedge link_clk) disable iff (!rstn)
      (line_sync_out & line_data_out) == 2'h0)
      else $error("sync and data tone together");
   c_accept: cover property (@(posedge clk) offer_accept);
   c_alarm: cover property (@(posedge clk) $rose(out_alarm));
   c_taken: cover property (@(posedge clk) word_taken);
endmodule

bind tboc_top tboc_checker #(.PHASE_CYC(PHASE_CYC), .BSTEP_CYC(BSTEP_CYC))
   u_chk (.clk(clk), .rstn(rstn), .link_clk(link_clk),
   .offer_burst_num(offer_burst_num), .offer_valid(offer_valid),
   .offer_other_ok(offer_other_ok), .offer_accept(offer_accept),
   .burst_compare(burst_compare), .burst_no_compare(burst_no_compare),
   .burst_count(burst_count), .burst_cnt_clear(burst_cnt_clear),
   .word_taken(word_taken), .out_alarm(out_alarm),
   .alarm_clear(alarm_clear), .tone_in(tone_in),
   .line_data_out(line_data_out),
   .line_sync_out(line_sync_out), .line_timing_out(line_timing_out));

// ===== test/tboc_line_term.sv
`timescale 1ns/1ps
module tboc_line_term
(
   input  wire logic        link_clk,
   input  wire logic        rstn,
   input  wire logic [1:0]  line_data_out,
   input  wire logic [1:0]  line_sync_out,
   output logic             tone_in,
   output logic [1:0][7:0]  data_cnt,
   output logic [1:0][7:0]  sync_cnt
);
   logic [1:0][3:0] dgap;
   logic [1:0][3:0] sgap;
   // tone runs faster than scaled bit rate so each one bit holds tone edges
   initial
   begin
      tone_in = 1'b0;
      forever #400 tone_in = ~tone_in;
   end
   // a gated burst starts at a rise after a long quiet spell
   always_ff @(posedge link_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         dgap     <= '1;
         sgap     <= '1;
         data_cnt <= '0;
         sync_cnt <= '0;
      end
      else
         for (int i = 0; i < 2; i++)
         begin
            dgap[i] <= line_data_out[i] ? 4'h0
                       : dgap[i] + {3'h0, dgap[i] != 4'hf};
            sgap[i] <= line_sync_out[i] ? 4'h0
                       : sgap[i] + {3'h0, sgap[i] != 4'hf};
            if (line_data_out[i] && dgap[i] >= 4'hc)
               data_cnt[i] <= data_cnt[i] + 8'h01;
            if (line_sync_out[i] && sgap[i] >= 4'hc)
               sync_cnt[i] <= sync_cnt[i] + 8'h01;
         end
   end
endmodule

// ===== test/tboc_top_tb.sv
`timescale 1ns/1ps
module tboc_top_tb;
   localparam int PH = 200;
   localparam int BS = 13600;
   logic            clk, rstn, link_clk, tone_in;
   logic [7:0]      offer_burst_num, burst_count;
   logic            offer_valid, offer_other_ok, offer_accept;
   logic            burst_compare, burst_no_compare, burst_cnt_clear;
   logic            msg_complete, word_taken, out_alarm, alarm_clear;
   logic [16:0]     word_line1, word_line2;
   logic [1:0]      line_data_out, line_sync_out, line_timing_out;
   logic [1:0][7:0] data_cnt, sync_cnt;
   int              n_mismatch, checked, n_taken;

   tboc_top #(.PHASE_CYC(PH), .BSTEP_CYC(BS)) uut (.clk(clk), .rstn(rstn),
      .link_clk(link_clk), .offer_burst_num(offer_burst_num),
      .offer_valid(offer_valid), .offer_other_ok(offer_other_ok),
      .offer_accept(offer_accept), .burst_compare(burst_compare),
      .burst_no_compare(burst_no_compare), .burst_count(burst_count),
      .burst_cnt_clear(burst_cnt_clear), .msg_complete(msg_complete),
      .word_line1(word_line1), .word_line2(word_line2),
      .word_taken(word_taken), .out_alarm(out_alarm),
      .alarm_clear(alarm_clear), .tone_in(tone_in),
      .line_data_out(line_data_out), .line_sync_out(line_sync_out),
      .line_timing_out(line_timing_out));
   tboc_line_term u_term (.link_clk(link_clk), .rstn(rstn),
      .line_data_out(line_data_out), .line_sync_out(line_sync_out),
      .tone_in(tone_in), .data_cnt(data_cnt), .sync_cnt(sync_cnt));

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   always @(posedge clk)
      if (word_taken === 1'b1)
         n_taken++;

   task automatic complete_run();
      $display("compares %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [16:0] exp,
                        input logic [16:0] got);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", what, exp, got);
      end
   endtask
   // bounded wait: 0 count reaches one, 1 words taken, 2 alarm up
   task automatic wait_for(input int sel, input int lim);
      int i;
      for (i = 0; i < lim; i++)
      begin
         @(posedge clk);
         #1;
         if ((sel == 0 && burst_count === 8'h01) ||
             (sel == 1 && word_taken === 1'b1) ||
             (sel == 2 && out_alarm === 1'b1))
            break;
      end
      if (i == lim)
      begin
         n_mismatch++;
         $display("mismatch wait %0d exp 1 got 0", sel);
         complete_run();
      end
   endtask
   task automatic t_compare(input logic [7:0] c);
      for (int b = 0; b < 12; b++)
      begin
         @(posedge clk);
         offer_burst_num <= (b < 8) ? c ^ (8'h01 << b) : c;
         offer_valid     <= (b < 8) || b[0];
         offer_other_ok  <= (b < 8) || b[1];
         @(negedge clk);
         check("no_compare", {16'h0, b < 8}, burst_no_compare);
         check("compare", {16'h0, b >= 8}, burst_compare);
         check("accept", {16'h0, b == 11}, offer_accept);
      end
   endtask
   task automatic t_burst();
      wait_for(0, BS + 20);
      wait_for(1, 40 * PH);
      @(posedge clk);
      msg_complete <= 1'b0;
      wait_for(2, 20 * PH);
      @(posedge clk);
      alarm_clear <= 1'b1;
      @(posedge clk);
      alarm_clear <= 1'b0;
      repeat (20 * PH) @(posedge clk);
      #1;
      check("alarm", 17'h0, out_alarm);
      check("taken", 17'h1, n_taken[16:0]);
      check("data1", 17'h4, data_cnt[0]);
      check("data2", 17'h3, data_cnt[1]);
      check("sync1", 17'h1, sync_cnt[0]);
      check("sync2", 17'h1, sync_cnt[1]);
   endtask
   task automatic t_after_reset();
      @(negedge clk);
      check("count", 17'h0, burst_count);
      check("lines", 17'h0, line_data_out);
   endtask
   task automatic t_clear();
      @(posedge clk);
      burst_cnt_clear <= 1'b1;
      @(posedge clk);
      burst_cnt_clear <= 1'b0;
      @(negedge clk);
      check("cleared", 17'h0, burst_count);
   endtask

   initial
   begin
      rstn = 1'b0;
      offer_burst_num = 8'h00;
      offer_valid = 1'b0;
      offer_other_ok = 1'b0;
      burst_cnt_clear = 1'b0;
      alarm_clear = 1'b0;
      msg_complete = 1'b1;
      word_line1 = 17'h10003;
      word_line2 = 17'h00005;
      // reset is asynchronous, so both domains clear without waiting
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      t_after_reset();
      t_compare(8'h00);
      t_burst();
      t_compare(8'h01);
      t_clear();
      complete_run();
   end
endmodule
